// File: core/snv_pkg.sv
// Shared constants and types for the serial nonvolatile memory front end
package snv_pkg;

   // Array geometry
   localparam int unsigned ADDR_W    = 13;
   localparam int unsigned MEM_DEPTH = 8192;
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned FIFO_W    = ADDR_W + DATA_W;
   localparam int unsigned FIFO_D    = 16;

   // Command codes
   localparam logic [7:0] OPC_LATCH_WRITE_ENABLE_CMD_LATCH = 8'h06;
   localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
   localparam logic [7:0] OPC_STAT_READ  = 8'h05;
   localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
   localparam logic [7:0] OPC_MEM_READ   = 8'h03;
   localparam logic [7:0] OPC_MEM_WRITE  = 8'h02;

   // Status byte field positions
   localparam int unsigned STAT_HWP_BIT  = 7;
   localparam int unsigned STAT_BPH_BIT  = 3;
   localparam int unsigned STAT_BPL_BIT  = 2;
   localparam int unsigned STAT_WEL_BIT  = 1;

   // Values after reset
   localparam logic       HWP_RESET = 1'b0;
   localparam logic [1:0] BP_RESET  = 2'h0;
   localparam logic       WEL_RESET = 1'b0;

   // Block-protect boundaries and address step
   localparam logic [ADDR_W-1:0] PROT_QUARTER_LO = 13'h1800;
   localparam logic [ADDR_W-1:0] PROT_HALF_LO    = 13'h1000;
   localparam logic [ADDR_W-1:0] ADDR_ONE        = 13'h0001;

   // Bit counter end and start values
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [2:0] FIRST_BIT = 3'h0;

   // Frame phases, Gray along opcode, address, write data
   typedef enum logic [2:0] {
      SNV_OPC     = 3'b000,
      SNV_ADDR_HI = 3'b001,
      SNV_ADDR_LO = 3'b011,
      SNV_WDATA   = 3'b010,
      SNV_RDATA   = 3'b110,
      SNV_SR_WR   = 3'b111,
      SNV_SR_RD   = 3'b101,
      SNV_IGNORE  = 3'b100
   } snv_phase_t;

endpackage

// File: core/snv_stream_if.sv
// Valid/ready stream between the command engine and the write buffer
`timescale 1ns/1ps
interface snv_stream_if #(
   parameter int unsigned W = 21
);
   logic         push_valid;
   logic         push_ready;
   logic [W-1:0] push_data;
   logic         pop_valid;
   logic         pop_ready;
   logic [W-1:0] pop_data;

   modport buf_side (
      input  push_valid,
      input  push_data,
      output push_ready,
      output pop_valid,
      output pop_data,
      input  pop_ready
   );

   modport user_side (
      output push_valid,
      output push_data,
      input  push_ready,
      input  pop_valid,
      input  pop_data,
      output pop_ready
   );
endinterface

// File: core/snv_fifo.sv
// Write-data buffer between the serial engine and the array
`timescale 1ns/1ps
module snv_fifo #(
   parameter int unsigned W     = 21,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic        ref_clk_in,
   input  wire logic        rstn_in,
   snv_stream_if.buf_side   st
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } snv_fifo_state_t;

   snv_fifo_state_t q;
   snv_fifo_state_t d;
   logic            full;
   logic            empty;

   always_comb begin
      full  = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
      empty = (q.wp == q.rp);
      d     = q;
      if (st.push_valid && !full) begin
         d.mem[q.wp[AW-1:0]] = st.push_data;
         d.wp                = q.wp + 1'b1;
      end
      if (st.pop_ready && !empty) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign st.push_ready = !full;
   assign st.pop_valid  = !empty;
   assign st.pop_data   = q.mem[q.rp[AW-1:0]];
endmodule

// File: core/snv_spi_mem.sv
// Serial command front end: op-codes, address, protection and array
`timescale 1ns/1ps
// Function
// [R01] 8192 bytes, 13-bit address from two address bytes, top three bits ignored
// [R02] Only modes 0 and 3; clock level sampled at each select fall
// [R03] Byte groups MSB first; sample on rising, drive on falling clock
// [R04] First byte after select is the op-code, address and data follow
// [R05] One op-code per select frame; master deselects between operations
// [R06] Latch-enable 06h and write-disable 04h carry no further bytes
// [R07] Status read 05h returns a byte; status write 01h takes one
// [R08] Memory read 03h and write 02h take address then data bytes
// [R09] Write enable latch clear after reset; writes refused until enabled
// [R10] Only the enable command sets the latch; status writes leave it
// [R11] Latch clears at select rise after disable, status write or memory write
// [R12] Master enables before each write; with latch clear writes are refused
// [R13] Status read shifts out the current status contents
// [R14] Status: bit7 hw protect, bits3:2 block protect, bit1 latch, rest zero
// [R15] Protect bits are kept as nonvolatile state; here reset clears hwp and bp to zero
// [R16] Block protect 00 none, 01 upper quarter, 10 upper half, 11 all
// [R17] Protect pin ignored unless hw protect set; then low blocks status writes
// [R18] Protect pin never gates array writes, only latch and block bits
// [R19] Master holds protect pin high before a status write
// [R20] Writes finish at bus speed, no busy indication
// [R21] In mode 3 the master drops clock before the first bit
// [R22] Master keeps serial clock at or below 20 MHz
// [R23] Select high: standby, inputs ignored, output tri-stated
// [R24] Pause low suspends operation, ignores clock and select, output off
// [R25] Burst address increments per byte, wraps from top to zero
// [R26] Each write byte committed after its eighth bit, no page buffer
// [R27] Byte to protected address discarded silently, address still advances
// [R28] Refused status write keeps status bits, latch still clears at select rise
module snv_spi_mem #(
   parameter int unsigned FIFO_DEPTH = snv_pkg::FIFO_D
) (
   input  wire logic ref_clk_in,
   input  wire logic rstn_in,
   input  wire logic sck_in,
   input  wire logic select_n_in,
   input  wire logic si_in,
   input  wire logic pause_n_in,
   input  wire logic write_protect_n_in,
   output logic      so_out,
   output logic      so_oe_out,
   output logic      mode3_out
);

   typedef struct packed {
      logic [2:0]               sck_s;
      logic [1:0]               sel_s;
      logic [1:0]               si_s;
      logic [1:0]               pause_s;
      logic [1:0]               wp_s;
      snv_pkg::snv_phase_t      phase;
      logic [2:0]               bit_cnt;
      logic [6:0]               in_sr;
      logic [7:0]               out_sr;
      logic [snv_pkg::ADDR_W-1:0] addr;
      logic                     rd_op;
      logic                     in_frame;
      logic                     out_act;
      logic                     clr_pend;
      logic                     write_enable_latch_flag;
      logic                     hwp;
      logic [1:0]               bp;
      logic                     mode3;
      logic                     so;
      logic                     so_oe;
   } snv_state_t;

   snv_state_t q;
   snv_state_t d;

   // Array storage; not reset, it models the nonvolatile cells
   logic [7:0] mem_q [snv_pkg::MEM_DEPTH];

   snv_stream_if #(.W(snv_pkg::FIFO_W)) wbuf ();

   logic                       push_v;
   logic [snv_pkg::FIFO_W-1:0] push_d;
   logic                       sck_lvl;
   logic                       sck_rise;
   logic                       sck_fall;
   logic                       sel_n;
   logic                       run;
   logic                       wp_n;
   logic [7:0]                 rx_byte;
   logic [snv_pkg::ADDR_W-1:0] start_addr;
   logic                       stat_wr_ok;

   function automatic logic [7:0] status_byte(input logic hwp, input logic [1:0] bp, input logic write_enable_latch_flag);
      logic [7:0] s;
      s                        = 8'h00;
      s[snv_pkg::STAT_HWP_BIT] = hwp;
      s[snv_pkg::STAT_BPH_BIT] = bp[1];
      s[snv_pkg::STAT_BPL_BIT] = bp[0];
      s[snv_pkg::STAT_WEL_BIT] = write_enable_latch_flag;
      return s;
   endfunction

   function automatic logic is_protected(input logic [1:0] bp, input logic [snv_pkg::ADDR_W-1:0] a);
      logic p;
      p = 1'b0;
      unique case (bp)                                                              // R16
         2'b00: p = 1'b0;
         2'b01: p = (a >= snv_pkg::PROT_QUARTER_LO);
         2'b10: p = (a >= snv_pkg::PROT_HALF_LO);
         2'b11: p = 1'b1;
      endcase
      return p;
   endfunction

   always_comb begin
      d          = q;
      push_v     = 1'b0;
      push_d     = '0;
      // Pins cross into the core clock through two flops each; the clock gets a third flop for edge detection
      d.sck_s    = {q.sck_s[1:0], sck_in};
      d.sel_s    = {q.sel_s[0], select_n_in};
      d.si_s     = {q.si_s[0], si_in};
      d.pause_s  = {q.pause_s[0], pause_n_in};
      d.wp_s     = {q.wp_s[0], write_protect_n_in};
      sck_lvl    = q.sck_s[1];
      sck_rise   = q.sck_s[1] & ~q.sck_s[2];
      sck_fall   = ~q.sck_s[1] & q.sck_s[2];
      sel_n      = q.sel_s[1];
      run        = q.pause_s[1];
      wp_n       = q.wp_s[1];
      rx_byte    = {q.in_sr, q.si_s[1]};
      start_addr = {q.addr[snv_pkg::ADDR_W-1:8], rx_byte};                        // R01
      stat_wr_ok = q.write_enable_latch_flag && !(q.hwp && !wp_n);                                      // R12 R17

      // While paused nothing advances; select and clock are ignored
      if (run) begin                                                                // R24
         if (sel_n) begin                                                           // R23
            if (q.in_frame) begin
               if (q.clr_pend) begin
                  d.write_enable_latch_flag = 1'b0;                                                     // R11
               end
               d.clr_pend = 1'b0;
               d.in_frame = 1'b0;
               d.out_act  = 1'b0;
               d.phase    = snv_pkg::SNV_OPC;
            end
         end else if (!q.in_frame) begin
            // Fresh select: clock level tells mode 3 from mode 0
            d.in_frame = 1'b1;
            d.mode3    = sck_lvl;                                                   // R02
            d.phase    = snv_pkg::SNV_OPC;                                          // R04
            d.bit_cnt  = snv_pkg::FIRST_BIT;
            d.rd_op    = 1'b0;
            d.out_act  = 1'b0;
         end else begin
            if (sck_rise) begin
               d.in_sr   = rx_byte[6:0];                                            // R03
               d.bit_cnt = q.bit_cnt + 3'h1;
               if (q.bit_cnt == snv_pkg::LAST_BIT) begin
                  unique case (q.phase)
                     snv_pkg::SNV_OPC: begin
                        // Anything other than a known code idles out the frame
                        d.phase = snv_pkg::SNV_IGNORE;                              // R05
                        if (rx_byte == snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH) begin
                           d.write_enable_latch_flag = 1'b1;                                            // R10
                        end else if (rx_byte == snv_pkg::OPC_WR_DISABLE) begin
                           d.clr_pend = 1'b1;                                       // R06
                        end else if (rx_byte == snv_pkg::OPC_STAT_READ) begin
                           d.out_sr  = status_byte(q.hwp, q.bp, q.write_enable_latch_flag);             // R13
                           d.out_act = 1'b1;
                           d.phase   = snv_pkg::SNV_SR_RD;                          // R07
                        end else if (rx_byte == snv_pkg::OPC_STAT_WRITE) begin
                           d.clr_pend = 1'b1;
                           d.phase    = snv_pkg::SNV_SR_WR;                         // R07
                        end else if (rx_byte == snv_pkg::OPC_MEM_READ) begin
                           d.rd_op = 1'b1;
                           d.phase = snv_pkg::SNV_ADDR_HI;                          // R08
                        end else if (rx_byte == snv_pkg::OPC_MEM_WRITE) begin
                           d.rd_op    = 1'b0;
                           d.clr_pend = 1'b1;
                           d.phase    = snv_pkg::SNV_ADDR_HI;                       // R08
                        end
                     end
                     snv_pkg::SNV_ADDR_HI: begin
                        // Top three address bits are dropped
                        d.addr[snv_pkg::ADDR_W-1:8] = rx_byte[snv_pkg::ADDR_W-9:0]; // R01
                        d.phase = snv_pkg::SNV_ADDR_LO;
                     end
                     snv_pkg::SNV_ADDR_LO: begin
                        if (q.rd_op) begin
                           d.out_sr  = mem_q[start_addr];
                           d.out_act = 1'b1;
                           d.addr    = start_addr + snv_pkg::ADDR_ONE;              // R25
                           d.phase   = snv_pkg::SNV_RDATA;
                        end else begin
                           d.addr  = start_addr;
                           d.phase = snv_pkg::SNV_WDATA;
                        end
                     end
                     snv_pkg::SNV_WDATA: begin
                        // Only the latch and block bits gate the array
                        if (q.write_enable_latch_flag && !is_protected(q.bp, q.addr)) begin             // R12 R18
                           push_v = 1'b1;                                           // R26
                           push_d = {q.addr, rx_byte};
                        end
                        d.addr = q.addr + snv_pkg::ADDR_ONE;                        // R27
                     end
                     snv_pkg::SNV_RDATA: begin
                        d.out_sr = mem_q[q.addr];
                        d.addr   = q.addr + snv_pkg::ADDR_ONE;                      // R25
                     end
                     snv_pkg::SNV_SR_WR: begin
                        // Refused update keeps every bit; latch still clears later
                        if (stat_wr_ok) begin                                       // R28
                           d.hwp = rx_byte[snv_pkg::STAT_HWP_BIT];                  // R15
                           d.bp  = {rx_byte[snv_pkg::STAT_BPH_BIT], rx_byte[snv_pkg::STAT_BPL_BIT]}; // R14
                        end
                        d.phase = snv_pkg::SNV_IGNORE;
                     end
                     snv_pkg::SNV_SR_RD: begin
                        d.out_sr = status_byte(q.hwp, q.bp, q.write_enable_latch_flag);                 // R14
                     end
                     snv_pkg::SNV_IGNORE: begin
                        d.phase = snv_pkg::SNV_IGNORE;
                     end
                  endcase
               end
            end
            if (sck_fall && q.out_act) begin
               d.so     = q.out_sr[7];                                              // R03
               d.out_sr = {q.out_sr[6:0], 1'b0};
            end
         end
      end
      // Driver only on while selected, running and answering
      d.so_oe = d.out_act && d.in_frame && run && !sel_n;                           // R23
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q          <= '0;
         q.sck_s    <= 3'h0;
         q.sel_s    <= 2'h3;
         q.pause_s  <= 2'h3;
         q.wp_s     <= 2'h3;
         q.phase    <= snv_pkg::SNV_OPC;
         q.write_enable_latch_flag      <= snv_pkg::WEL_RESET;                                          // R09
         q.hwp      <= snv_pkg::HWP_RESET;
         q.bp       <= snv_pkg::BP_RESET;
      end else begin
         q <= d;
      end
   end

   // Writes drain a byte per cycle, so the array never reports busy
   assign wbuf.push_valid = push_v;                                                 // R20
   assign wbuf.push_data  = push_d;
   // Drain stalls while paused; a full buffer drops the incoming byte
   assign wbuf.pop_ready  = run;

   snv_fifo #(
      .W     (snv_pkg::FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .ref_clk_in (ref_clk_in),
      .rstn_in    (rstn_in),
      .st         (wbuf)
   );

   always_ff @(posedge ref_clk_in) begin
      if (wbuf.pop_valid && wbuf.pop_ready) begin
         mem_q[wbuf.pop_data[snv_pkg::FIFO_W-1:8]] <= wbuf.pop_data[7:0];          // R26
      end
   end

   assign so_out    = q.so;
   assign so_oe_out = q.so_oe;
   assign mode3_out = q.mode3;

endmodule

// File: bench/snv_spi_mem_checker.sv
// Concurrent checks on the serial memory pins
`timescale 1ns/1ps
module snv_spi_mem_checker (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic sck_in,
   input wire logic select_n_in,
   input wire logic si_in,
   input wire logic pause_n_in,
   input wire logic write_protect_n_in,
   input wire logic so_out,
   input wire logic so_oe_out,
   input wire logic mode3_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // Six samples cover the two-flop delay plus the registered enable
   property p_standby_off;
      select_n_in [*6] |-> !so_oe_out;
   endproperty
   a_standby_off: assert property (p_standby_off)
      else $error("output driven while deselected");
   property p_pause_off;
      !pause_n_in [*6] |-> !so_oe_out;
   endproperty
   a_pause_off: assert property (p_pause_off)
      else $error("output driven while paused");
   property p_mode3;
      $fell(select_n_in) && sck_in |-> ##[2:6] mode3_out;
   endproperty
   a_mode3: assert property (p_mode3)
      else $error("mode 3 not detected");
   property p_mode0;
      $fell(select_n_in) && !sck_in |-> ##[2:6] !mode3_out;
   endproperty
   a_mode0: assert property (p_mode0)
      else $error("mode 0 not detected");
   property p_mode_hold;
      $changed(mode3_out) |-> $past(select_n_in, 4);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("mode changed away from a select fall");
   property p_so_fall;
      so_oe_out && $past(so_oe_out) && $changed(so_out) |-> !$past(sck_in, 2);
   endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("data out changed off a falling clock");
   property p_oe_start;
      $rose(so_oe_out) |-> !select_n_in && pause_n_in;
   endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("output enabled outside an active frame");
   property p_oe_holds;
      so_oe_out && !select_n_in && pause_n_in |=> so_oe_out;
   endproperty
   a_oe_holds: assert property (p_oe_holds)
      else $error("output dropped inside a read");
   c_read: cover property ($rose(so_oe_out));
   c_mode3: cover property ($fell(select_n_in) && sck_in);
   c_pause: cover property (!pause_n_in [*6]);
endmodule

bind snv_spi_mem snv_spi_mem_checker chk (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sck_in(sck_in), .select_n_in(select_n_in),
   .si_in(si_in), .pause_n_in(pause_n_in), .write_protect_n_in(write_protect_n_in),
   .so_out(so_out), .so_oe_out(so_oe_out), .mode3_out(mode3_out));

// File: bench/snv_host_model.sv
// Host serial master model driving the memory pins
`timescale 1ns/1ps
module snv_host_model (
   input  wire logic ref_clk_in,
   input  wire logic so_in,
   input  wire logic so_oe_in,
   output logic      sck_out,
   output logic      select_n_out,
   output logic      si_out
);
   logic mode3;
   initial begin
      mode3        = 1'b0;
      sck_out      = 1'b0;
      select_n_out = 1'b1;
      si_out       = 1'b1;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask
   // Clock parked at idle level long before select falls
   task automatic open_frame();
      sck_out <= mode3;
      idle(8);
      select_n_out <= 1'b0;
      idle(8);
   endtask
   // 40 ns half periods keep well under the clock ceiling
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_out <= 1'b0;
         si_out  <= tx[i];
         idle(4);
         sck_out <= 1'b1;
         idle(4);
         rx[i] = so_oe_in ? so_in : ~tx[i]; // Undriven line reads as the inverse of the bit sent
      end
   endtask
   task automatic close_frame();
      idle(4);
      sck_out <= mode3;
      idle(4);
      select_n_out <= 1'b1;
      si_out       <= ~si_out; // Released line, not the last bit
      idle(8);
   endtask
endmodule

// File: bench/snv_spi_mem_test.sv
// Self-checking bench for the serial memory front end
`timescale 1ns/1ps
module snv_spi_mem_test;
   logic        ref_clk_in;
   logic        rstn_in;
   logic        pause_n;
   logic        wp_n;
   logic        sck;
   logic        select_n;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        mode3;
   logic [7:0]  rx;
   int          n_errors;
   int          num_checks;
   logic [7:0]  mem [logic [12:0]];
   logic [12:0] starts [3] = '{13'h0FFF, 13'h17FF, 13'h1FFF};

   snv_spi_mem DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sck_in(sck), .select_n_in(select_n),
      .si_in(si), .pause_n_in(pause_n), .write_protect_n_in(wp_n), .so_out(so), .so_oe_out(so_oe),
      .mode3_out(mode3));
   snv_host_model host (.ref_clk_in(ref_clk_in), .so_in(so), .so_oe_in(so_oe), .sck_out(sck),
      .select_n_out(select_n), .si_out(si));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] opc);
      host.open_frame();
      host.xfer(opc, rx);
      host.close_frame();
   endtask
   task automatic cmd2(input logic [7:0] opc, input logic [7:0] d, output logic [7:0] r);
      host.open_frame();
      host.xfer(opc, rx);
      host.xfer(d, r);
      host.close_frame();
   endtask
   task automatic burst(input logic [7:0] opc, input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
                        output logic [7:0] r0, output logic [7:0] r1);
      host.open_frame();
      host.xfer(opc, rx);
      host.xfer(a[15:8], rx);
      host.xfer(a[7:0], rx);
      host.xfer(d0, r0);
      host.xfer(d1, r1);
      host.close_frame();
   endtask
   function automatic logic blocked(input logic [1:0] bp, input logic [12:0] a);
      case (bp)
         2'h0:    blocked = 1'b0;
         2'h1:    blocked = (a >= 13'h1800);
         2'h2:    blocked = (a >= 13'h1000);
         default: blocked = 1'b1;
      endcase
   endfunction

   task automatic t_latch();
      logic [7:0] r;
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status after reset", r, 8'h00);
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status after enable", r, 8'h02);
      cmd(snv_pkg::OPC_WR_DISABLE);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status after disable", r, 8'h00);
   endtask
   task automatic t_status();
      logic [7:0] r;
      cmd2(snv_pkg::OPC_STAT_WRITE, 8'h8C, r);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status write without latch", r, 8'h00);
      wp_n <= 1'b1;
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      cmd2(snv_pkg::OPC_STAT_WRITE, 8'hFF, r);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status after full write", r, 8'h8C);
      wp_n <= 1'b0;
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      cmd2(snv_pkg::OPC_STAT_WRITE, 8'h00, r);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status write under pin", r, 8'h8C);
      wp_n <= 1'b1;
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      cmd2(snv_pkg::OPC_STAT_WRITE, 8'h00, r);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("status write pin released", r, 8'h00);
   endtask
   // Pause only moves while the clock idles low; a frame sent meanwhile must be ignored
   task automatic t_pause();
      logic [7:0] r;
      pause_n <= 1'b0;
      host.idle(4);
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      pause_n <= 1'b1;
      host.idle(4);
      cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r);
      check("latch after paused enable", r, 8'h00);
   endtask
   // Pin held low throughout: ignored with hw protect clear, never gates the array
   task automatic t_protect();
      logic [7:0] r0;
      logic [7:0] r1;
      logic [7:0] d;
      wp_n <= 1'b0;
      for (int bp = 0; bp < 4; bp++) begin
         host.mode3 = bp[0];
         cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
         cmd2(snv_pkg::OPC_STAT_WRITE, {4'h0, bp[1:0], 2'h3}, r0);
         cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r0);
         check("block protect status", r0, {4'h0, bp[1:0], 2'h0});
         for (int k = 0; k < 3; k++) begin
            d = {bp[1:0], 2'(k), 4'h5};
            cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
            burst(snv_pkg::OPC_MEM_WRITE, {3'h7, starts[k]}, d, ~d, r0, r1);
            if (!blocked(bp[1:0], starts[k])) mem[starts[k]] = d;
            if (!blocked(bp[1:0], starts[k] + 13'h0001)) mem[starts[k] + 13'h0001] = ~d;
         end
         cmd2(snv_pkg::OPC_STAT_READ, 8'h00, r0);
         check("latch after array write", r0, {4'h0, bp[1:0], 2'h0});
         check("mode flag", {7'h00, mode3}, {7'h00, bp[0]});
         for (int k = 0; k < 3; k++) begin
            burst(snv_pkg::OPC_MEM_READ, {3'h0, starts[k]}, 8'h00, 8'h00, r0, r1);
            check("first burst byte", r0, mem[starts[k]]);
            check("second burst byte", r1, mem[starts[k] + 13'h0001]);
         end
      end
      cmd(snv_pkg::OPC_LATCH_WRITE_ENABLE_CMD_LATCH);
      cmd2(snv_pkg::OPC_STAT_WRITE, 8'h00, r0);
      burst(snv_pkg::OPC_MEM_WRITE, 16'h0FFF, 8'h11, 8'h22, r0, r1);
      burst(snv_pkg::OPC_MEM_READ, 16'h0FFF, 8'h00, 8'h00, r0, r1);
      check("array write without latch", r0, mem[13'h0FFF]);
   endtask

   initial begin
      repeat (100000) @(posedge ref_clk_in);
      n_errors++;
      give_verdict();
   end
   initial begin
      rstn_in    = 1'b0;
      pause_n    = 1'b1;
      wp_n       = 1'b1;
      n_errors   = 0;
      num_checks = 0;
      repeat (20) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      host.idle(4);
      t_latch();
      t_status();
      t_pause();
      t_protect();
      give_verdict();
   end
endmodule
